// file: rtl/sfe_cmd_core.sv
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module sfe_cmd_core #(
  parameter logic [7:0] LATCH_SET_OPC  = sfe_pkg::DEF_OPC_LATCH_SET,
  parameter logic [7:0] SR_ARM_OPC     = sfe_pkg::DEF_OPC_SR_ARM,
  parameter logic [7:0] SR_WRITE_OPC   = sfe_pkg::DEF_OPC_SR_WRITE,
  parameter logic [7:0] MAKER_ID       = sfe_pkg::DEF_MAKER_ID,
  parameter logic [7:0] PART_ID        = sfe_pkg::DEF_PART_ID,
  parameter logic [7:0] TYPE_ID        = sfe_pkg::DEF_TYPE_ID,
  parameter logic [7:0] CAP_ID         = sfe_pkg::DEF_CAP_ID,
  parameter int         BLK_ERASE_CYC  = sfe_pkg::BLK_ERASE_CYC,
  parameter int         CHIP_ERASE_CYC = sfe_pkg::CHIP_ERASE_CYC
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire sfe_pkg::sfe_spi_pins_s spi_in,
  input  wire sfe_pkg::sfe_axi_req_s  axi_in,
  output sfe_pkg::sfe_axi_rsp_s       axi_out,
  output logic                       so_out,
  output logic                       so_oe_out,
  output sfe_pkg::sfe_erase_s         erase_out,
  output logic                       busy_out
);
  import sfe_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic                  sck_q;     // Previous synced clock
    logic                  sel_q;     // Previous synced select
    sfe_phase_e            phase;     // Frame phase
    logic [7:0]            opcode;    // Latched opcode
    logic [31:0]           in_sr;     // Serial input shifter
    logic [5:0]            nbits;     // Bits seen, saturating
    logic [7:0]            out_sr;    // Serial output shifter
    logic [2:0]            out_cnt;   // Bit within output byte
    logic [1:0]            out_idx;   // Identity byte pointer
    logic                  so;        // Data out level
    logic                  so_oe;     // Data out drive
    logic                  wel;       // Write latch
    logic                  auto_increment_program_mode;       // Auto-increment mode
    logic [BP_W-1:0]       bp;        // Protect level bits
    logic                  protect_lock_bit;       // Protect lock bit
    logic                  arm;       // Status write armed
    logic                  busy;      // Internal operation
    logic [BUSY_CNT_W-1:0] busy_cnt;  // Cycles left busy
    sfe_erase_s            erase;     // Erase request out
    logic                  link_dis;  // Software link disable
    logic [15:0]           tally;     // Erases started
    logic                  aw_held;   // Write address taken
    logic [AXI_AW-1:0]     aw_addr;
    logic                  w_held;    // Write data taken
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    sfe_axi_rsp_s          rsp;       // Bus answer
  } sfe_core_s;

  sfe_core_s     st_reg;   // Registered state
  sfe_core_s     st_next;  // Next state
  sfe_spi_pins_s pins;     // Synced pin levels
  logic          sck_rise; // Pin edges in the clk_in domain
  logic          sck_fall;
  logic          cs_rise;
  logic          cs_fall;
  logic          exec_go;  // Frame of a command ends

  // Status byte as seen on the link and the bus
  function automatic logic [7:0] status_byte(input sfe_core_s s);
    return {s.protect_lock_bit, s.auto_increment_program_mode, s.bp, s.wel, s.busy};
  endfunction

  // Word address match for the register map
  function automatic logic reg_hit(input logic [AXI_AW-1:0] a,
                                   input logic [7:0] off);
    return a[AXI_AW-1:2] == off[AXI_AW-1:2];
  endfunction

  // Protected 64 KByte blocks grow down from the top of the array
  function automatic logic blk_protected(input logic [BP_W-1:0] lvl,
                                         input logic [BLK_IDX_W-1:0] idx);
    logic [BLK_IDX_W:0] first;
    first = NUM_BLK64 - (7'h01 << (lvl - 4'h1));
    if (lvl == '0) begin
      return 1'b0;
    end else if (lvl >= PROT_ALL_LVL) begin
      return 1'b1;
    end else begin
      return {1'b0, idx} >= first;
    end
  endfunction

  // Pins come from the host's domain, two flops first
  sfe_pin_sync #(
    .W       (4),
    .RST_VAL (SPI_PINS_IDLE)
  ) u_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .raw_in   (spi_in),
    .sync_out (pins)
  );

  // Edges from synced level against its own delayed copy
  assign sck_rise = pins.sck & ~st_reg.sck_q;
  assign sck_fall = ~pins.sck & st_reg.sck_q;
  assign cs_rise  = pins.cs_n & st_reg.sel_q;
  assign cs_fall  = ~pins.cs_n & ~st_reg.sel_q;
  assign exec_go  = cs_rise && st_reg.phase == PH_IN;

  // Next-state logic: link, command execution, busy timer, bus
  always_comb begin
    st_next             = st_reg;
    st_next.sck_q       = pins.sck;
    st_next.sel_q       = ~pins.cs_n;
    st_next.erase.start = 1'b0;

    // Busy countdown; counts the full parameter length
    if (st_reg.busy_cnt > 24'h000001) begin
      st_next.busy_cnt = st_reg.busy_cnt - 24'h000001;
    end else if (st_reg.busy) begin
      st_next.busy_cnt = '0;
      st_next.busy     = 1'b0;
    end

    // Frame start; ignored while software holds the link off
    if (cs_fall && !st_reg.link_dis) begin
      st_next.phase = PH_IN;
      st_next.nbits = '0;
    end else if (cs_rise && st_reg.phase != PH_IDLE) begin
      // Any frame end stops output and spends the arming
      st_next.phase = PH_IDLE;
      st_next.so_oe = 1'b0;
      st_next.arm   = 1'b0;
      if (exec_go) begin
        // Executed only now, never mid-frame
        if (st_reg.opcode == LATCH_SET_OPC && st_reg.nbits == BITS_SHORT
            && !st_reg.busy) begin
          st_next.wel = 1'b1;
        end else if (st_reg.opcode == OPC_LATCH_CLEAR
                     && st_reg.nbits == BITS_SHORT) begin
          // Busy timer left running on purpose
          st_next.wel = 1'b0;
          st_next.auto_increment_program_mode = 1'b0;
        end else if (st_reg.opcode == SR_ARM_OPC
                     && st_reg.nbits == BITS_SHORT && !st_reg.busy) begin
          st_next.arm = 1'b1;
        end else if (st_reg.opcode == SR_WRITE_OPC
                     && st_reg.nbits == BITS_DATA && !st_reg.busy
                     && (st_reg.arm || st_reg.wel)) begin
          st_next.wel = 1'b0;
          // Pin and lock sampled at this select edge
          if (pins.wp_n || !st_reg.protect_lock_bit) begin
            st_next.bp  = st_reg.in_sr[SR_BP_LO +: BP_W];
            st_next.protect_lock_bit = st_reg.in_sr[SR_BPL];
          end
        end else if ((st_reg.opcode == OPC_BLK32
                      || st_reg.opcode == OPC_BLK64)
                     && st_reg.nbits == BITS_ADDR && !st_reg.busy
                     && st_reg.wel) begin
          st_next.wel = 1'b0;
          if (!blk_protected(st_reg.bp,
                             st_reg.in_sr[BLK64_LSB +: BLK_IDX_W])) begin
            st_next.erase.start = 1'b1;
            st_next.busy        = 1'b1;
            st_next.busy_cnt    = BUSY_CNT_W'(BLK_ERASE_CYC);
            st_next.tally       = st_reg.tally + 16'h0001;
            if (st_reg.opcode == OPC_BLK32) begin
              st_next.erase.kind = ERASE_BLK32;
              st_next.erase.addr = st_reg.in_sr[23:0] & BLK32_MASK;
            end else begin
              st_next.erase.kind = ERASE_BLK64;
              st_next.erase.addr = st_reg.in_sr[23:0] & BLK64_MASK;
            end
          end
        end else if ((st_reg.opcode == OPC_CHIP_A
                      || st_reg.opcode == OPC_CHIP_B)
                     && st_reg.nbits == BITS_SHORT && !st_reg.busy
                     && st_reg.wel) begin
          st_next.wel = 1'b0;
          if (st_reg.bp == '0) begin
            st_next.erase.start = 1'b1;
            st_next.erase.kind  = ERASE_CHIP;
            st_next.erase.addr  = '0;
            st_next.busy        = 1'b1;
            st_next.busy_cnt    = BUSY_CNT_W'(CHIP_ERASE_CYC);
            st_next.tally       = st_reg.tally + 16'h0001;
          end
        end
      end
    end else if (st_reg.phase != PH_IDLE && sck_rise) begin
      // Input sampled on the serial clock's rising edge
      st_next.in_sr = {st_reg.in_sr[30:0], pins.si};
      if (st_reg.nbits != 6'h3F) begin
        st_next.nbits = st_reg.nbits + 6'h01;
      end
      if (st_reg.phase == PH_IN && st_reg.nbits == BITS_OPC_LAST) begin
        st_next.opcode  = {st_reg.in_sr[6:0], pins.si};
        st_next.out_cnt = '0;
        if (st_next.opcode == OPC_STATUS_RD) begin
          // Answered in every state, busy included
          st_next.phase  = PH_STATUS;
          st_next.out_sr = status_byte(st_reg);
        end else if (st_next.opcode == OPC_JEDEC_ID) begin
          st_next.phase   = PH_JEDEC;
          st_next.out_sr  = MAKER_ID;
          st_next.out_idx = 2'h1;
        end
      end else if (st_reg.phase == PH_IN
                   && st_reg.nbits == BITS_ADDR_LAST
                   && (st_reg.opcode == OPC_LEG_ID_A
                       || st_reg.opcode == OPC_LEG_ID_B)) begin
        // Address bit 0 picks the first byte
        st_next.phase      = PH_LEGACY;
        st_next.out_sr     = pins.si ? PART_ID : MAKER_ID;
        st_next.out_idx[0] = ~pins.si;
        st_next.out_cnt    = '0;
      end
    end else if (sck_fall && (st_reg.phase == PH_STATUS
                              || st_reg.phase == PH_LEGACY
                              || st_reg.phase == PH_JEDEC)) begin
      // Output changes on the falling edge, most significant first
      st_next.so      = st_reg.out_sr[7];
      st_next.so_oe   = 1'b1;
      st_next.out_sr  = {st_reg.out_sr[6:0], 1'b0};
      st_next.out_cnt = st_reg.out_cnt + 3'h1;
      if (st_reg.out_cnt == 3'h7) begin
        case (st_reg.phase)
          PH_STATUS: begin
            st_next.out_sr = status_byte(st_reg);
          end
          PH_LEGACY: begin
            st_next.out_sr     = st_reg.out_idx[0] ? PART_ID : MAKER_ID;
            st_next.out_idx[0] = ~st_reg.out_idx[0];
          end
          default: begin
            // Past the third byte the line reads zero
            case (st_reg.out_idx)
              2'h1:    st_next.out_sr = TYPE_ID;
              2'h2:    st_next.out_sr = CAP_ID;
              default: st_next.out_sr = '0;
            endcase
            if (st_reg.out_idx != 2'h3) begin
              st_next.out_idx = st_reg.out_idx + 2'h1;
            end
          end
        endcase
      end
    end

    // Bus write: address and data taken in either order
    if (st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid) begin
      st_next.aw_held    = 1'b0;
      st_next.w_held     = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = RESP_OKAY;
      if (reg_hit(st_reg.aw_addr, REG_CTRL)) begin
        if (st_reg.w_strb[0]) begin
          st_next.link_dis = st_reg.w_data[0];
        end
      end else if (!reg_hit(st_reg.aw_addr, REG_STATUS)
                   && !reg_hit(st_reg.aw_addr, REG_ERASES)) begin
        st_next.rsp.bresp = RESP_SLVERR;  // Unmapped
      end
    end else if (st_reg.rsp.bvalid && axi_in.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    if (axi_in.awvalid && st_reg.rsp.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = axi_in.awaddr;
    end
    if (axi_in.wvalid && st_reg.rsp.wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = axi_in.wdata;
      st_next.w_strb = axi_in.wstrb;
    end
    // One write at a time keeps the ready logic trivial
    st_next.rsp.awready = ~st_next.aw_held & ~st_next.rsp.bvalid;
    st_next.rsp.wready  = ~st_next.w_held & ~st_next.rsp.bvalid;

    // Bus read: answer one cycle after the address is taken
    if (st_reg.rsp.rvalid && axi_in.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end else if (axi_in.arvalid && st_reg.rsp.arready) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rresp  = RESP_OKAY;
      if (reg_hit(axi_in.araddr, REG_CTRL)) begin
        st_next.rsp.rdata = {31'h0, st_reg.link_dis};
      end else if (reg_hit(axi_in.araddr, REG_STATUS)) begin
        st_next.rsp.rdata = {23'h0, pins.wp_n, status_byte(st_reg)};
      end else if (reg_hit(axi_in.araddr, REG_ERASES)) begin
        st_next.rsp.rdata = {16'h0, st_reg.tally};
      end else begin
        st_next.rsp.rdata = '0;
        st_next.rsp.rresp = RESP_SLVERR;
      end
    end
    st_next.rsp.arready = ~st_next.rsp.rvalid;
  end

  // All-zero reset is the idle state by construction
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axi_out   = st_reg.rsp;
  assign so_out    = st_reg.so;
  assign so_oe_out = st_reg.so_oe;
  assign erase_out = st_reg.erase;
  assign busy_out  = st_reg.busy;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // Erase kick followed by busy
  sequence erase_kick;
    erase_out.start ##1 busy_out;
  endsequence

  chk_erase_busy: assert property (erase_out.start |-> erase_kick)
    else $error("busy not raised by erase");
  chk_blk32_align: assert property (erase_out.start &&
      erase_out.kind == ERASE_BLK32 |-> erase_out.addr[14:0] == 15'h0)
    else $error("32K erase address not aligned");
  chk_blk64_align: assert property (erase_out.start &&
      erase_out.kind == ERASE_BLK64 |-> erase_out.addr[15:0] == 16'h0)
    else $error("64K erase address not aligned");
  chk_erase_latch: assert property (erase_out.start |->
      $past(st_reg.wel) && !st_reg.wel && $past(cs_rise))
    else $error("erase without latch or select edge");
  chk_chip_unprot: assert property (erase_out.start &&
      erase_out.kind == ERASE_CHIP |-> $past(st_reg.bp) == '0)
    else $error("whole erase while protected");
  chk_sr_write_wel: assert property (exec_go &&
      st_reg.opcode == SR_WRITE_OPC && st_reg.nbits == BITS_DATA
      && !st_reg.busy |=> !st_reg.wel)
    else $error("latch not cleared by status write");
  chk_lock_holds: assert property (!pins.wp_n && st_reg.protect_lock_bit
      |=> st_reg.protect_lock_bit)
    else $error("lock bit cleared with pin low");
  chk_clear_no_abort: assert property (exec_go &&
      st_reg.opcode == OPC_LATCH_CLEAR && st_reg.busy_cnt > 24'h000001
      |=> busy_out && !st_reg.wel)
    else $error("latch clear disturbed busy");
  chk_status_cont: assert property (st_reg.phase == PH_STATUS
      && !cs_rise |=> st_reg.phase == PH_STATUS)
    else $error("status output stopped early");
  chk_id_end: assert property (cs_rise && st_reg.phase != PH_IDLE
      |=> !so_oe_out && st_reg.phase == PH_IDLE)
    else $error("output not ended by select");
endmodule

// file: rtl/sfe_pkg.sv
package sfe_pkg;
  // Fixed opcodes of the command set
  localparam logic [7:0] OPC_BLK32       = 8'h52;
  localparam logic [7:0] OPC_BLK64       = 8'hD8;
  localparam logic [7:0] OPC_CHIP_A      = 8'h60;
  localparam logic [7:0] OPC_CHIP_B      = 8'hC7;
  localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OPC_STATUS_RD   = 8'h05;
  localparam logic [7:0] OPC_LEG_ID_A    = 8'h90;
  localparam logic [7:0] OPC_LEG_ID_B    = 8'hAB;
  localparam logic [7:0] OPC_JEDEC_ID    = 8'h9F;
  // Defaults for opcodes that are module parameters
  localparam logic [7:0] DEF_OPC_LATCH_SET = 8'h16;
  localparam logic [7:0] DEF_OPC_SR_ARM    = 8'h17;
  localparam logic [7:0] DEF_OPC_SR_WRITE  = 8'h18;
  // Identity codes, values arbitrary
  localparam logic [7:0] DEF_MAKER_ID = 8'h5A;
  localparam logic [7:0] DEF_PART_ID  = 8'h3D;
  localparam logic [7:0] DEF_TYPE_ID  = 8'h3C;
  localparam logic [7:0] DEF_CAP_ID   = 8'h2E;
  // Status byte layout
  localparam int SR_BP_LO = 2;
  localparam int SR_BPL   = 7;
  localparam int BP_W     = 4;
  // Command lengths in serial bits
  localparam logic [5:0] BITS_SHORT = 6'h08;
  localparam logic [5:0] BITS_DATA  = 6'h10;
  localparam logic [5:0] BITS_ADDR  = 6'h20;
  localparam logic [5:0] BITS_OPC_LAST  = 6'h07;
  localparam logic [5:0] BITS_ADDR_LAST = 6'h1F;
  // Array geometry and protection
  localparam int BLK64_LSB = 16;
  localparam int BLK_IDX_W = 6;
  localparam logic [6:0]  NUM_BLK64    = 7'h40;
  localparam logic [3:0]  PROT_ALL_LVL = 4'h7;
  localparam logic [23:0] BLK32_MASK   = 24'hFF8000;
  localparam logic [23:0] BLK64_MASK   = 24'hFF0000;
  // Erase timing
  localparam int CLK_KHZ = 50000;
  localparam int T_BE_MS = 25;
  localparam int T_CE_MS = 50;
  localparam int BLK_ERASE_CYC  = T_BE_MS * CLK_KHZ;
  localparam int CHIP_ERASE_CYC = T_CE_MS * CLK_KHZ;
  localparam int BUSY_CNT_W     = 24;
  // Register map
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERASES = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin idle levels: sck, cs_n, si, wp_n
  localparam logic [3:0] SPI_PINS_IDLE = 4'h5;

  typedef enum logic [1:0] {ERASE_BLK32, ERASE_BLK64, ERASE_CHIP} sfe_erase_e;
  typedef enum logic [2:0] {PH_IDLE, PH_IN, PH_STATUS, PH_LEGACY,
                            PH_JEDEC} sfe_phase_e;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
  } sfe_spi_pins_s;

  typedef struct packed {
    logic        start;
    sfe_erase_e  kind;
    logic [23:0] addr;
  } sfe_erase_s;

  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } sfe_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sfe_axi_rsp_s;
endpackage

// file: rtl/sfe_pin_sync.sv
`timescale 1ns/1ps
module sfe_pin_sync #(
  parameter int            W       = 4,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] sync_out
);
  // Two stages per pin; only the second is read outside
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sfe_sync_s;

  sfe_sync_s st_reg;   // Current stages
  sfe_sync_s st_next;  // Next stages

  // Shift one stage per clock
  always_comb begin
    st_next.meta = raw_in;
    st_next.sync = st_reg.meta;
  end

  // Reset to idle pin levels so no false edge appears
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.sync;
endmodule

// file: sim/sfe_host_model.sv
`timescale 1ns/1ps
// Host controller on the serial link, mode 0, clock still between frames
module sfe_host_model
  import sfe_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           wp_n_in,
  input  wire logic           so_in,
  input  wire logic           so_oe_in,
  output sfe_pkg::sfe_spi_pins_s pins_out
);
  logic sck_r  = 1'b0;  // Serial clock, low when idle
  logic cs_n_r = 1'b1;  // Select, high when idle
  logic si_r   = 1'b0;  // Data towards the device
  assign pins_out = {sck_r, cs_n_r, si_r, wp_n_in};
  // One frame, MSB first; select stays low over every bit
  task automatic xfer(input logic [63:0] d, input int n,
                      output logic [63:0] q);
    q = '0;
    @(posedge clk_in) cs_n_r <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_r <= d[i];
      repeat (4) @(posedge clk_in);
      sck_r <= 1'b1;
      // Undriven output shows no stale bit
      q = {q[62:0], so_oe_in ? so_in : ~q[0]};
      repeat (4) @(posedge clk_in);
      sck_r <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    cs_n_r <= 1'b1;
    si_r <= ~si_r;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// file: sim/sfe_cmd_core_tb.sv
`timescale 1ns/1ps
// Queue-checked bench: link frames from the host model, bus tasks
module sfe_cmd_core_tb;
  import sfe_pkg::*;
  localparam int         BLK = 300;
  localparam int         CHIP = 600;
  localparam logic [7:0] SET = DEF_OPC_LATCH_SET;
  localparam logic [7:0] ARM = DEF_OPC_SR_ARM;
  logic          clk = 1'b0;   // System clock
  logic          rst = 1'b1;   // Synchronous reset
  logic          wp_n = 1'b1;  // Write-protect pin
  sfe_spi_pins_s pins;         // Link pins from the host
  sfe_axi_req_s  axi = '0;     // Bus requests
  sfe_axi_rsp_s  rsp;          // Bus answers
  sfe_erase_s    er;           // Erase events
  logic          so;           // Serial out
  logic          so_oe;        // Serial out enable
  logic          busy;         // Busy level
  logic [33:0]   er_q[$];      // Expected erases
  logic [33:0]   rd_q[$];      // Expected read answers
  logic [63:0]   q;            // Bits caught on the link
  logic [23:0]   a;            // Random address
  logic [7:0]    ops[4] = '{OPC_BLK32, OPC_BLK64, OPC_CHIP_A, OPC_CHIP_B};
  logic [23:0]   msk[4] = '{BLK32_MASK, BLK64_MASK, 24'h0, 24'h0};
  int            err_count = 0;
  int            checks = 0;
  int            bcnt = 0;     // Busy cycles seen
  int            dur = 0;      // Busy cycles expected
  initial forever #10 clk = ~clk;
  sfe_cmd_core #(.BLK_ERASE_CYC(BLK), .CHIP_ERASE_CYC(CHIP)) DUT (
    .clk_in(clk), .reset_in(rst), .spi_in(pins), .axi_in(axi),
    .axi_out(rsp), .so_out(so), .so_oe_out(so_oe), .erase_out(er),
    .busy_out(busy));
  sfe_host_model host (.clk_in(clk), .wp_n_in(wp_n), .so_in(so),
    .so_oe_in(so_oe), .pins_out(pins));
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Results appear here; erases and reads take the oldest note off their queue, busy length is checked against dur
  always @(posedge clk) begin
    if (er.start === 1'b1) begin
      if (er_q.size() == 0) chk(34'h1, 34'h0);
      else chk({8'h0, er.kind, er.addr}, er_q.pop_front());
    end
    if (rsp.rvalid === 1'b1 && axi.rready)
      chk({rsp.rresp, rsp.rdata}, rd_q.pop_front());
    if (busy === 1'b1) bcnt++;
    else if (bcnt != 0) begin
      chk(34'(bcnt), 34'(dur));
      bcnt = 0;
    end
  end
  task automatic xf(input logic [63:0] d, input int n);
    host.xfer(d, n, q);
  endtask
  // Status read over two bytes: byte repeats
  task automatic sr_rd(input logic [7:0] e);
    xf({40'h0, OPC_STATUS_RD, 16'h0}, 24);
    chk({18'h0, q[15:0]}, {18'h0, e, e});
  endtask
  // Optional enabling frame, status write, then read back
  task automatic sr_wr(input logic [7:0] en, input logic [7:0] v,
                       input logic [7:0] e);
    if (en != 8'h00) xf({56'h0, en}, 8);
    xf({48'h0, DEF_OPC_SR_WRITE, v}, 16);
    sr_rd(e);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [1:0] e);
    axi.awaddr <= ad;
    axi.wdata <= '0;
    axi.wstrb <= 4'hF;
    axi.awvalid <= 1'b1;
    axi.wvalid <= 1'b1;
    axi.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (axi.awvalid && rsp.awready) axi.awvalid <= 1'b0;
      if (axi.wvalid && rsp.wready) axi.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    chk({32'h0, rsp.bresp}, {32'h0, e});
    axi.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [33:0] e);
    rd_q.push_back(e);
    axi.araddr <= ad;
    axi.arvalid <= 1'b1;
    axi.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (axi.arvalid && rsp.arready) axi.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    axi.rready <= 1'b0;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(44762));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    a = 24'($urandom);
    xf({32'h0, OPC_BLK32, a}, 32);
    sr_rd(8'h00);
    for (int k = 0; k < 4; k++) begin
      a = 24'($urandom);
      xf({56'h0, SET}, 8);
      sr_rd(8'h02);
      er_q.push_back({8'h0, (k > 1) ? 2'd2 : 2'(k), a & msk[k]});
      dur = (k > 1) ? CHIP : BLK;
      if (k > 1) xf({56'h0, ops[k]}, 8);
      else xf({32'h0, ops[k], a}, 32);
      sr_rd(8'h01);
      // Latch clear mid whole erase; busy length still checked
      if (k > 1) xf({56'h0, OPC_LATCH_CLEAR}, 8);
      if (k > 1) sr_rd(8'h01);
      while (busy !== 1'b0) @(posedge clk);
    end
    rd(REG_ERASES, {RESP_OKAY, 32'h4});
    rd(8'h0C, {RESP_SLVERR, 32'h0});
    wr(REG_CTRL, RESP_OKAY);
    wr(8'h10, RESP_SLVERR);
    $display("test erase and bus done");
    sr_wr(ARM, 8'h1C, 8'h1C);
    xf({56'h0, SET}, 8);
    xf({32'h0, OPC_BLK32, a}, 32);
    xf({56'h0, SET}, 8);
    xf({56'h0, OPC_CHIP_B}, 8);
    sr_rd(8'h1C);
    xf({56'h0, ARM}, 8);
    sr_rd(8'h1C);
    sr_wr(8'h00, 8'h00, 8'h1C);
    sr_wr(SET, 8'h00, 8'h00);
    @(posedge clk) wp_n <= 1'b0;
    sr_wr(ARM, 8'h84, 8'h84);
    rd(REG_STATUS, {RESP_OKAY, 32'h84});
    sr_wr(ARM, 8'h00, 8'h84);
    @(posedge clk) wp_n <= 1'b1;
    sr_wr(ARM, 8'h00, 8'h00);
    xf({56'h0, SET}, 8);
    xf({56'h0, OPC_LATCH_CLEAR}, 8);
    sr_rd(8'h00);
    $display("test protection done");
    xf({32'h0, OPC_JEDEC_ID, 24'h0}, 32);
    chk({10'h0, q[23:0]}, {10'h0, DEF_MAKER_ID, DEF_TYPE_ID, DEF_CAP_ID});
    for (int k = 0; k < 2; k++) begin
      a = {23'($urandom), k[0]};
      xf(64'({k ? OPC_LEG_ID_B : OPC_LEG_ID_A, a, 24'h0}), 56);
      chk({10'h0, q[23:0]}, k ? {10'h0, DEF_PART_ID, DEF_MAKER_ID,
        DEF_PART_ID} : {10'h0, DEF_MAKER_ID, DEF_PART_ID, DEF_MAKER_ID});
      chk({33'h0, so_oe}, 34'h0);
    end
    $display("test identity done");
    report_and_stop();
  end
endmodule
